// >>> src/ndjb_pkg.sv
/*
  Shared constants, enums and helpers of the network dejitter buffer.
  Assumes a single 10 MHz clock; time values count clock cycles.
*/
package ndjb_pkg;
  // ----------------------------------------
  // widths and defaults
  // ----------------------------------------
  localparam int TIME_W        = 32;
  localparam int CR_BYTES      = 4;
  localparam int LEN_W         = 11;
  localparam int DESC_AW       = 3;
  localparam int PACE_W        = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int JITTER_NS_DEF = 1_000_000;
  localparam int RATE_BPS_DEF  = 2_000_000;
  localparam int DEC_BITS_DEF  = 4096;
  localparam int EXTRA_BITS    = 512;
  localparam longint NS_PER_S  = 64'd1_000_000_000;

  // ----------------------------------------
  // byte positions inside a transport packet
  // ----------------------------------------
  localparam logic [LEN_W-1:0] PID_HI_IDX = 11'h001;
  localparam logic [LEN_W-1:0] PID_LO_IDX = 11'h002;
  localparam logic [LEN_W-1:0] AFC_IDX    = 11'h003;
  localparam logic [LEN_W-1:0] AFLEN_IDX  = 11'h004;
  localparam logic [LEN_W-1:0] AFFLAG_IDX = 11'h005;
  localparam logic [LEN_W-1:0] PCR_IDX    = 11'h006;
  localparam logic [LEN_W-1:0] PCR_END    = 11'h009;
  localparam logic [1:0]       CR_LAST    = 2'h3;

  // ----------------------------------------
  // modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_TSTAMP = 2'h0,
    MODE_CBR    = 2'h1,
    MODE_COMMON = 2'h2,
    MODE_INTEG  = 2'h3
  } ndjb_mode_e;
  typedef enum logic [2:0] {
    ENC_IDLE = 3'h1, ENC_HDR = 3'h2, ENC_PAY = 3'h4
  } ndjb_enc_e;
  typedef enum logic [1:0] {RX_CR = 2'h1, RX_BODY = 2'h2} ndjb_rx_e;
  typedef enum logic [1:0] {RL_IDLE = 2'h1, RL_SEND = 2'h2} ndjb_rl_e;

  // wrap-safe "now has reached stamp"
  function automatic logic timeReached(logic [TIME_W-1:0] now,
                                       logic [TIME_W-1:0] stamp);
    logic [TIME_W-1:0] diff;
    diff = now - stamp;
    return !diff[TIME_W-1];
  endfunction

  // byte address width for a buffer of the given bit size
  function automatic int bufAddrW(longint bits);
    return $clog2((bits + 64'd7) / 64'd8);
  endfunction
endpackage

// >>> src/ndjb_buf_if.sv
/*
  Carrier between the control logic and the packet store.
  Assumes both ends run on the same clock.
*/
interface ndjb_buf_if #(parameter int AW = 10);
  logic          wr;
  logic [7:0]    wrData;
  logic          commit;
  logic          abort;
  logic          rd;
  logic [7:0]    rdData;
  logic          full;
  logic          empty;
  logic [AW:0]   fill;
  modport owner (output wr, wrData, commit, abort, rd,
                 input  rdData, full, empty, fill);
  modport store (input  wr, wrData, commit, abort, rd,
                 output rdData, full, empty, fill);
endinterface

// >>> src/ndjb_pkt_mem.sv
/*
  Byte store with a speculative write pointer so whole packets are
  committed or thrown away. Assumes abort never meets a read of
  uncommitted data (reads stop at the committed pointer).
*/
module ndjb_pkt_mem #(
  parameter int AW = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ndjb_buf_if.store bus
);
  localparam logic [AW:0] DEPTH = {1'b1, {AW{1'b0}}};

  logic [7:0]  mem [2**AW];
  logic [AW:0] wrPtr_q, wrPtr_d;
  logic [AW:0] comPtr_q, comPtr_d;
  logic [AW:0] rdPtr_q, rdPtr_d;

  // ----------------------------------------
  // pointer arithmetic
  // ----------------------------------------
  // abort rewinds to the last committed packet end
  always_comb begin
    wrPtr_d  = bus.wr ? wrPtr_q + 1'b1 : wrPtr_q;
    comPtr_d = bus.commit ? wrPtr_d : comPtr_q;
    if (bus.abort) begin
      wrPtr_d = comPtr_q;
    end
    rdPtr_d = bus.rd ? rdPtr_q + 1'b1 : rdPtr_q;
  end

  // full counts speculative bytes, empty only committed ones
  assign bus.full   = (wrPtr_q - rdPtr_q) == DEPTH;
  assign bus.empty  = comPtr_q == rdPtr_q;
  assign bus.fill   = comPtr_q - rdPtr_q;
  assign bus.rdData = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_q  <= '0;
      comPtr_q <= '0;
      rdPtr_q  <= '0;
    end else if (ce) begin
      wrPtr_q  <= wrPtr_d;
      comPtr_q <= comPtr_d;
      rdPtr_q  <= rdPtr_d;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge clk) begin
    if (ce && bus.wr) begin
      mem[wrPtr_q[AW-1:0]] <= bus.wrData;
    end
  end
endmodule

// >>> src/ndjb_top.sv
/*
  Network dejitter buffer: stamping packet encoder, stamp stripping
  receiver, time recovery, packet store and paced/scheduled release.
  Assumes the mode input is static between resets and that network
  input cannot be stalled (losses show as overflow).
*/
module ndjb_top #(
  parameter int JITTER_NS = ndjb_pkg::JITTER_NS_DEF,
  parameter int RATE_BPS  = ndjb_pkg::RATE_BPS_DEF,
  parameter int DEC_BITS  = ndjb_pkg::DEC_BITS_DEF
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic [1:0]                  mode,
  input  wire logic [12:0]                 selPid,
  input  wire logic                        encInValid,
  input  wire logic [7:0]                  encInData,
  input  wire logic                        encInLast,
  output logic                             encInReady,
  output logic                             encOutValid,
  output logic [7:0]                       encOutData,
  output logic                             encOutLast,
  input  wire logic                        encOutReady,
  input  wire logic                        netInValid,
  input  wire logic [7:0]                  netInData,
  input  wire logic                        netInLast,
  output logic                             decOutValid,
  output logic [7:0]                       decOutData,
  output logic                             decOutLast,
  input  wire logic                        decOutReady,
  input  wire logic                        auStampValid,
  input  wire logic [ndjb_pkg::TIME_W-1:0] auStamp,
  output logic                             auReady,
  output logic                             auDecode,
  output logic [ndjb_pkg::TIME_W-1:0]      recoveredTime,
  output logic [15:0]                      fillLevel,
  output logic                             overflow,
  output logic                             underflow
);
  localparam int TW = ndjb_pkg::TIME_W;
  localparam int LW = ndjb_pkg::LEN_W;
  localparam int PW = ndjb_pkg::PACE_W;
  localparam longint JIT_BITS = longint'(JITTER_NS) * longint'(RATE_BPS)
                                / ndjb_pkg::NS_PER_S;
  localparam longint INT_BITS = longint'(DEC_BITS)
                                + longint'(ndjb_pkg::EXTRA_BITS) + JIT_BITS;
  localparam int AW = ndjb_pkg::bufAddrW(INT_BITS);
  // half of the jitter share is the nominal fill
  localparam logic [AW:0] HALF_FILL = (AW+1)'(JIT_BITS / 64'd16);
  // delay derived from the shared jitter bound
  localparam logic [TW-1:0] HALF_J =
    TW'(JITTER_NS / 2 / ndjb_pkg::CLK_PERIOD_NS);
  localparam logic [PW-1:0] PACE_NOM =
    PW'(8 * ndjb_pkg::CLK_HZ / RATE_BPS);
  localparam logic [PW-1:0] PACE_MIN = PACE_NOM >> 1;
  localparam logic [PW-1:0] PACE_MAX = PW'({PACE_NOM, 1'b0});

  ndjb_buf_if #(.AW(AW)) bufBus ();
  ndjb_pkt_mem #(.AW(AW)) store (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .bus (bufBus.store)
  );

  ndjb_pkg::ndjb_mode_e modeSel;
  logic stripCr, streamMode;
  assign modeSel    = ndjb_pkg::ndjb_mode_e'(mode);
  assign stripCr    = modeSel == ndjb_pkg::MODE_TSTAMP
                   || modeSel == ndjb_pkg::MODE_INTEG;
  assign streamMode = !stripCr;

  // ----------------------------------------
  // local time clock and encoder
  // ----------------------------------------
  ndjb_pkg::ndjb_enc_e encSt_q, encSt_d;
  logic [TW-1:0] localTime_q, localTime_d, stamp_q, stamp_d;
  logic [1:0]    hdrCnt_q, hdrCnt_d;
  logic          encInReady_q, encInReady_d;
  logic          encOutValid_q, encOutValid_d, encOutLast_q, encOutLast_d;
  logic [7:0]    encOutData_q, encOutData_d;
  logic          encFree;

  // ready is registered, so payload moves at most every other cycle
  always_comb begin
    localTime_d   = localTime_q + 1'b1;
    encSt_d       = encSt_q;
    stamp_d       = stamp_q;
    hdrCnt_d      = hdrCnt_q;
    encInReady_d  = encInReady_q;
    encOutData_d  = encOutData_q;
    encOutLast_d  = encOutLast_q;
    encFree       = !encOutValid_q || encOutReady;
    encOutValid_d = encOutValid_q && !encOutReady;
    unique case (encSt_q)
      ndjb_pkg::ENC_IDLE: if (encInValid && encFree) begin
        // stamp as the packet starts to leave
        stamp_d       = localTime_q;
        encOutData_d  = localTime_q[TW-1 -: 8];
        encOutLast_d  = 1'b0;
        encOutValid_d = 1'b1;
        hdrCnt_d      = 2'h1;
        encSt_d       = ndjb_pkg::ENC_HDR;
      end
      ndjb_pkg::ENC_HDR: if (encFree) begin
        encOutData_d  = stamp_q[8*(3-hdrCnt_q) +: 8];
        encOutValid_d = 1'b1;
        hdrCnt_d      = hdrCnt_q + 1'b1;
        if (hdrCnt_q == ndjb_pkg::CR_LAST) begin
          encSt_d = ndjb_pkg::ENC_PAY;
        end
      end
      ndjb_pkg::ENC_PAY: begin
        if (encInValid && encInReady_q) begin
          encOutData_d  = encInData;
          encOutLast_d  = encInLast;
          encOutValid_d = 1'b1;
          encInReady_d  = 1'b0;
          if (encInLast) begin
            encSt_d = ndjb_pkg::ENC_IDLE;
          end
        end else if (!encInReady_q && encFree && !encOutLast_q) begin
          encInReady_d = 1'b1;
        end
      end
    endcase
    if (encSt_q == ndjb_pkg::ENC_IDLE) begin
      encOutLast_d = encOutLast_q && !encOutReady;
    end
  end

  // ----------------------------------------
  // network receive and parse
  // ----------------------------------------
  ndjb_pkg::ndjb_rx_e rxSt_q, rxSt_d;
  logic [LW-1:0] rxIdx_q, rxIdx_d;
  logic [TW-1:0] cr_q, cr_d, pcr_q, pcr_d;
  logic [12:0]   pid_q, pid_d;
  logic          afOk_q, afOk_d, pcrFlag_q, pcrFlag_d;
  logic          drop_q, drop_d;
  logic          sample, late, rxOvf, pushDesc;
  logic [TW-1:0] sampleVal;
  logic [TW-1:0] recTime_q, recTime_d, delayed;
  logic          locked_q, locked_d;
  logic          descFull, descEmpty;
  assign delayed = recTime_q - HALF_J;

  always_comb begin
    rxSt_d = rxSt_q;   rxIdx_d = rxIdx_q;  cr_d = cr_q;
    pcr_d = pcr_q;     pid_d = pid_q;      afOk_d = afOk_q;
    pcrFlag_d = pcrFlag_q;                 drop_d = drop_q;
    sample = 1'b0;     sampleVal = cr_q;   late = 1'b0;
    rxOvf = 1'b0;      pushDesc = 1'b0;
    bufBus.wr = 1'b0;  bufBus.wrData = netInData;
    bufBus.commit = 1'b0;                  bufBus.abort = 1'b0;
    if (netInValid && rxSt_q == ndjb_pkg::RX_CR && stripCr) begin
      // stamp bytes never reach the store
      cr_d    = {cr_q[TW-9:0], netInData};
      rxIdx_d = rxIdx_q + 1'b1;
      if (rxIdx_q[1:0] == ndjb_pkg::CR_LAST) begin
        rxSt_d  = ndjb_pkg::RX_BODY;
        rxIdx_d = '0;
        sample    = modeSel == ndjb_pkg::MODE_TSTAMP;
        sampleVal = cr_d;
      end
    end else if (netInValid) begin
      // full store drops the rest of the packet
      if (bufBus.full || drop_q) begin
        rxOvf  = !drop_q;
        drop_d = 1'b1;
      end else begin
        bufBus.wr = 1'b1;
      end
      unique case (rxIdx_q)
        ndjb_pkg::PID_HI_IDX: pid_d[12:8] = netInData[4:0];
        ndjb_pkg::PID_LO_IDX: pid_d[7:0]  = netInData;
        ndjb_pkg::AFC_IDX:    afOk_d      = netInData[5];
        ndjb_pkg::AFLEN_IDX:  afOk_d      = afOk_q && netInData != 8'h00;
        ndjb_pkg::AFFLAG_IDX: pcrFlag_d   = afOk_q && netInData[4];
        default: if (rxIdx_q >= ndjb_pkg::PCR_IDX
                  && rxIdx_q <= ndjb_pkg::PCR_END) begin
          pcr_d = {pcr_q[TW-9:0], netInData};
        end
      endcase
      if (rxIdx_q == ndjb_pkg::AFC_IDX) begin
        pcrFlag_d = 1'b0;
      end
      if (rxIdx_q != {LW{1'b1}}) begin
        rxIdx_d = rxIdx_q + 1'b1;
      end
      // streaming modes commit byte by byte
      if (streamMode) begin
        bufBus.commit = bufBus.wr;
      end
      if (netInLast) begin
        rxIdx_d = '0;
        drop_d  = 1'b0;
        rxSt_d  = stripCr ? ndjb_pkg::RX_CR : ndjb_pkg::RX_BODY;
        if (stripCr) begin
          // pid filter; whole packets or none
          if (!bufBus.wr || descFull || (modeSel == ndjb_pkg::MODE_INTEG
              && pid_q != selPid)) begin
            bufBus.abort = 1'b1;
            rxOvf        = rxOvf || (descFull && !drop_q);
          end else begin
            bufBus.commit = 1'b1;
            pushDesc      = 1'b1;
            late = modeSel == ndjb_pkg::MODE_TSTAMP
                && ndjb_pkg::timeReached(delayed, cr_q) && delayed != cr_q;
          end
          // pcr of the selected pid steers the clock
          if (modeSel == ndjb_pkg::MODE_INTEG && pid_q == selPid
              && pcrFlag_q) begin
            sample    = 1'b1;
            sampleVal = pcr_q;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // time recovery
  // ----------------------------------------
  // first-order slew: a full loop filter is left to the system
  always_comb begin
    recTime_d = recTime_q + 1'b1;
    locked_d  = locked_q;
    if (sample && !locked_q) begin
      recTime_d = sampleVal;
      locked_d  = 1'b1;
    end else if (sample && sampleVal != recTime_q) begin
      recTime_d = ndjb_pkg::timeReached(sampleVal, recTime_q)
                ? recTime_q + 2'h2 : recTime_q;
    end
  end

  // ----------------------------------------
  // packet descriptors
  // ----------------------------------------
  logic [TW-1:0] descCr  [2**ndjb_pkg::DESC_AW];
  logic [LW-1:0] descLen [2**ndjb_pkg::DESC_AW];
  logic [ndjb_pkg::DESC_AW:0] dWp_q, dWp_d, dRp_q, dRp_d;
  logic popDesc;
  assign descFull  = (dWp_q - dRp_q) == {1'b1, {ndjb_pkg::DESC_AW{1'b0}}};
  assign descEmpty = dWp_q == dRp_q;
  always_comb begin
    dWp_d = pushDesc ? dWp_q + 1'b1 : dWp_q;
    dRp_d = popDesc ? dRp_q + 1'b1 : dRp_q;
  end
  always_ff @(posedge clk) begin
    if (ce && pushDesc) begin
      descCr[dWp_q[ndjb_pkg::DESC_AW-1:0]]  <= cr_q;
      descLen[dWp_q[ndjb_pkg::DESC_AW-1:0]] <= rxIdx_q + 1'b1;
    end
  end

  // ----------------------------------------
  // release, pacing and unit decode
  // ----------------------------------------
  ndjb_pkg::ndjb_rl_e rlSt_q, rlSt_d;
  logic [LW-1:0] remain_q, remain_d;
  logic [PW-1:0] pace_q, pace_d, interval_q, interval_d;
  logic          firstDone_q, firstDone_d, go, decFree;
  logic          decValid_q, decValid_d, decLast_q, decLast_d;
  logic [7:0]    decData_q, decData_d;
  logic          auPend_q, auPend_d, auDec_d, ufl;
  logic [TW-1:0] auStamp_q, auStamp_d, headCr;
  logic [LW-1:0] headLen;
  assign headCr  = descCr[dRp_q[ndjb_pkg::DESC_AW-1:0]];
  assign headLen = descLen[dRp_q[ndjb_pkg::DESC_AW-1:0]];

  always_comb begin
    rlSt_d = rlSt_q;   remain_d = remain_q;  firstDone_d = firstDone_q;
    interval_d = interval_q;                 decData_d = decData_q;
    decLast_d = decLast_q;                   pace_d = pace_q + 1'b1;
    decFree    = !decValid_q || decOutReady;
    decValid_d = decValid_q && !decOutReady;
    bufBus.rd = 1'b0;  popDesc = 1'b0;  ufl = late;
    auPend_d = auPend_q;  auStamp_d = auStamp_q;  auDec_d = 1'b0;
    // first release on equality; later ones once reached
    go = modeSel == ndjb_pkg::MODE_INTEG || (firstDone_q
       ? ndjb_pkg::timeReached(delayed, headCr) : delayed == headCr);
    if (streamMode) begin
      if (pace_q >= interval_q) begin
        if (!bufBus.empty && decFree) begin
          decData_d = bufBus.rdData;  decLast_d = 1'b0;
          decValid_d = 1'b1;          bufBus.rd = 1'b1;
          pace_d = '0;
          // steer rate to keep the fill near half
          if (modeSel == ndjb_pkg::MODE_CBR) begin
            if (bufBus.fill > HALF_FILL && interval_q > PACE_MIN) begin
              interval_d = interval_q - 1'b1;
            end else if (bufBus.fill < HALF_FILL
                         && interval_q < PACE_MAX) begin
              interval_d = interval_q + 1'b1;
            end
          end else begin
            interval_d = PACE_NOM;
          end
        end else if (bufBus.empty) begin
          ufl    = 1'b1;
          pace_d = '0;
        end else begin
          pace_d = pace_q;
        end
      end
    end else begin
      pace_d = '0;
      unique case (rlSt_q)
        ndjb_pkg::RL_IDLE: if (!descEmpty && go) begin
          rlSt_d = ndjb_pkg::RL_SEND;  remain_d = headLen;
          popDesc = 1'b1;              firstDone_d = 1'b1;
        end
        ndjb_pkg::RL_SEND: if (decFree && !bufBus.empty) begin
          decData_d  = bufBus.rdData;
          decLast_d  = remain_q == 11'h001;
          decValid_d = 1'b1;
          bufBus.rd  = 1'b1;
          remain_d   = remain_q - 1'b1;
          if (remain_q == 11'h001) begin
            rlSt_d = ndjb_pkg::RL_IDLE;
          end
        end
      endcase
    end
    // unit decoded when its stamp meets delayed time
    if (modeSel == ndjb_pkg::MODE_INTEG) begin
      if (!auPend_q && auStampValid) begin
        auPend_d = 1'b1;  auStamp_d = auStamp;
      end else if (auPend_q && delayed == auStamp_q) begin
        auPend_d = 1'b0;  auDec_d = 1'b1;
        ufl      = bufBus.empty;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // flags are one-cycle pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      localTime_q <= '0;  encSt_q <= ndjb_pkg::ENC_IDLE;
      stamp_q <= '0;      hdrCnt_q <= '0;   encInReady_q <= 1'b0;
      encOutValid_q <= 1'b0;  encOutData_q <= 8'h00;
      encOutLast_q <= 1'b0;   rxSt_q <= ndjb_pkg::RX_CR;
      rxIdx_q <= '0;  cr_q <= '0;  pcr_q <= '0;  pid_q <= '0;
      afOk_q <= 1'b0;  pcrFlag_q <= 1'b0;  drop_q <= 1'b0;
      recTime_q <= '0;  locked_q <= 1'b0;  dWp_q <= '0;  dRp_q <= '0;
      rlSt_q <= ndjb_pkg::RL_IDLE;  remain_q <= '0;  pace_q <= '0;
      interval_q <= PACE_NOM;  firstDone_q <= 1'b0;
      decValid_q <= 1'b0;  decData_q <= 8'h00;  decLast_q <= 1'b0;
      auPend_q <= 1'b0;  auStamp_q <= '0;  auReady <= 1'b0;
      auDecode <= 1'b0;  fillLevel <= 16'h0000;
      overflow <= 1'b0;  underflow <= 1'b0;
    end else if (ce) begin
      localTime_q <= localTime_d;  encSt_q <= encSt_d;
      stamp_q <= stamp_d;  hdrCnt_q <= hdrCnt_d;
      encInReady_q <= encInReady_d;  encOutValid_q <= encOutValid_d;
      encOutData_q <= encOutData_d;  encOutLast_q <= encOutLast_d;
      rxSt_q <= rxSt_d;  rxIdx_q <= rxIdx_d;  cr_q <= cr_d;
      pcr_q <= pcr_d;  pid_q <= pid_d;  afOk_q <= afOk_d;
      pcrFlag_q <= pcrFlag_d;  drop_q <= drop_d;
      recTime_q <= recTime_d;  locked_q <= locked_d;
      dWp_q <= dWp_d;  dRp_q <= dRp_d;  rlSt_q <= rlSt_d;
      remain_q <= remain_d;  pace_q <= pace_d;  interval_q <= interval_d;
      firstDone_q <= firstDone_d;  decValid_q <= decValid_d;
      decData_q <= decData_d;  decLast_q <= decLast_d;
      auPend_q <= auPend_d;  auStamp_q <= auStamp_d;
      auReady <= !auPend_d && modeSel == ndjb_pkg::MODE_INTEG;
      auDecode <= auDec_d;  fillLevel <= 16'(bufBus.fill);
      overflow <= rxOvf;  underflow <= ufl;
    end
  end

  assign encInReady    = encInReady_q;
  assign encOutValid   = encOutValid_q;
  assign encOutData    = encOutData_q;
  assign encOutLast    = encOutLast_q;
  assign decOutValid   = decValid_q;
  assign decOutData    = decData_q;
  assign decOutLast    = decLast_q;
  assign recoveredTime = recTime_q;
endmodule

// >>> tb/ndjb_assertions.sv
/* checker on the ndjb_top ports, bound below
   assumes ce is high while reset is held */
module ndjb_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [1:0]  mode,
  input wire logic        encInValid,
  input wire logic        encInReady,
  input wire logic        encOutValid,
  input wire logic [7:0]  encOutData,
  input wire logic        encOutReady,
  input wire logic        netInValid,
  input wire logic        decOutValid,
  input wire logic [7:0]  decOutData,
  input wire logic        decOutReady,
  input wire logic        auReady,
  input wire logic        auDecode,
  input wire logic [15:0] fillLevel,
  input wire logic        overflow
);
  timeunit 1ns;
  timeprecision 1ns;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_ENC_HOLD: assert property (encOutValid && !encOutReady |=>
    encOutValid && $stable(encOutData)) else $error("enc byte lost");
  AST_ENC_GAP: assert property (encInValid && encInReady |=>
    !encInReady) else $error("enc byte too soon");
  AST_DEC_HOLD: assert property (decOutValid && !decOutReady |=>
    decOutValid && $stable(decOutData)) else $error("dec byte lost");
  AST_OVF_CAUSE: assert property (overflow |-> $past(netInValid))
    else $error("overflow without input");
  AST_FILL_CAP: assert property (fillLevel <= 16'h0400)
    else $error("fill above store size");
  AST_FILL_RST: assert property ($fell(rst) |-> fillLevel == 16'h0000
    && !decOutValid) else $error("not empty after reset");
  AST_AU_MODE: assert property (auReady || auDecode |-> mode == 2'h3)
    else $error("unit path outside mode 3");
  AST_AU_PULSE: assert property (auDecode |=> !auDecode)
    else $error("decode pulse too long");
  COV_ENC: cover property (encOutValid && encOutReady);
  COV_DEC: cover property (decOutValid && decOutReady);
  COV_OVF: cover property (overflow);
  COV_AU: cover property (auDecode);
endmodule

bind ndjb_top ndjb_checker i_ndjb_checker (.clk, .rst, .mode, .encInValid,
  .encInReady, .encOutValid, .encOutData, .encOutReady, .netInValid,
  .decOutValid, .decOutData, .decOutReady, .auReady, .auDecode,
  .fillLevel, .overflow);

// >>> tb/ndjb_far_end.sv
/* far side: stamped network source and a slow stream sink
   assumes sendPkt is called at a rising clock edge */
module ndjb_far_end (
  input  wire logic  clk,
  output logic       netInValid,
  output logic [7:0] netInData,
  output logic       netInLast,
  output logic       decOutReady
);
  timeunit 1ns;
  timeprecision 1ns;
  // lines idle, sink stalled at start
  initial begin
    netInValid = 1'h0;
    netInLast = 1'h0;
    netInData = 8'h00;
    decOutReady = 1'h0;
  end
  // ready every other cycle so the output must hold under stalls
  always @(posedge clk) decOutReady <= !decOutReady;
  // stamp first, big-endian, shared time base
  task automatic sendPkt(input logic [31:0] st, input int n);
    for (int i = 0; i < n + 4; i++) begin
      @(posedge clk);
      netInValid <= 1'h1;
      netInData <= (i < 4) ? st[31-8*i -: 8] : 8'(i);
      netInLast <= (i == n + 3);
    end
    @(posedge clk);
    netInValid <= 1'h0;
    netInLast <= 1'h0;
    netInData <= ~netInData; // no stale byte left on idle lines
  endtask
endmodule

// >>> tb/tb_network_dejitter_buffer.sv
/* bench for ndjb_top in timestamp mode, then a unit decode run in integrated mode
   assumes the far-side model and the bound checker */
module tb_network_dejitter_buffer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int JIT = 20000; // short jitter keeps the run brief
  localparam int HALF = JIT / 2 / ndjb_pkg::CLK_PERIOD_NS;
  logic clk, rst, ce, encInValid, encInLast, encInReady, encOutValid;
  logic encOutLast, encOutReady, netInValid, netInLast, decOutValid;
  logic decOutLast, decOutReady, auStampValid, auReady, auDecode;
  logic overflow, underflow;
  logic [1:0]  mode;
  logic [12:0] selPid;
  logic [7:0]  encInData, encOutData, netInData, decOutData;
  logic [31:0] auStamp, recoveredTime, cyc, s1, s2, t1, t2;
  logic [15:0] fillLevel;
  int          err_count, n_tests, nOvf, nUnf;
  ndjb_top #(.JITTER_NS(JIT)) i_ndjb_top (.clk, .rst, .ce, .mode, .selPid,
    .encInValid, .encInData, .encInLast, .encInReady, .encOutValid,
    .encOutData, .encOutLast, .encOutReady, .netInValid, .netInData,
    .netInLast, .decOutValid, .decOutData, .decOutLast, .decOutReady,
    .auStampValid, .auStamp, .auReady, .auDecode, .recoveredTime,
    .fillLevel, .overflow, .underflow);
  ndjb_far_end i_ndjb_far_end (.clk, .netInValid, .netInData, .netInLast,
    .decOutReady);
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // edge count and pulse tallies, read at edges before they move
  always @(posedge clk) begin
    cyc <= cyc + 32'h0000_0001;
    nOvf <= nOvf + int'(overflow);
    nUnf <= nUnf + int'(underflow);
  end
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic waitEdge(inout int lim);
    @(posedge clk);
    lim--;
    if (lim < 0) begin
      chk("wait bound", 32'h0000_0000, 32'h0000_0001);
      wrap_up();
    end
  endtask
  // two payload bytes; t0 is the first edge with output valid
  task automatic encPkt(output logic [31:0] st, output logic [31:0] t0);
    logic [7:0] b [6];
    int n, lim;
    n = 0;
    lim = 100;
    encInValid <= 1'h1;
    encInData <= 8'hA5;
    while (n < 6) begin
      waitEdge(lim);
      encOutReady <= !encOutReady;
      if (!encOutValid && n == 0) t0 = cyc + 32'h0000_0001;
      if (encOutValid && encOutReady) begin
        b[n] = encOutData;
        if (n == 5) chk("enc last", 32'h1, 32'(encOutLast));
        n++;
      end
      if (encInValid && encInReady) begin
        encInValid <= !encInLast;
        encInLast <= !encInLast;
        encInData <= 8'h3C;
      end
    end
    st = {b[0], b[1], b[2], b[3]};
    chk("enc payload", 32'hA53C, {16'h0000, b[4], b[5]});
  endtask
  // three body bytes, released near stamp plus half jitter
  task automatic rxPkt(input logic [31:0] st);
    int n, lim;
    n = 0;
    lim = 400;
    while (n < 3) begin
      waitEdge(lim);
      if (decOutValid && decOutReady) begin
        if (n == 0)
          chk("release", 32'h1, 32'(recoveredTime - st - HALF < 12));
        chk("body", 32'(n + 4), 32'(decOutData));
        chk("last", 32'(n == 2), 32'(decOutLast));
        n++;
      end
    end
  endtask
  // unit decode in integrated mode after a fresh reset
  task automatic auRun;
    int lim;
    lim = 300;
    rst <= 1'h1;
    mode <= ndjb_pkg::MODE_INTEG;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    chk("au ready", 32'h1, 32'(auReady));
    auStampValid <= 1'h1;
    auStamp <= 32'h0000_0020;
    waitEdge(lim);
    auStampValid <= 1'h0;
    while (auDecode !== 1'h1) waitEdge(lim);
    chk("au time", 32'h0000_0020 + HALF + 1, recoveredTime);
    chk("au underflow", 32'h1, 32'(underflow));
    ce <= 1'h0;
    repeat (2) @(posedge clk);
    s1 = recoveredTime;
    repeat (2) @(posedge clk);
    chk("frozen time", s1, recoveredTime);
    ce <= 1'h1;
  endtask
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    mode = ndjb_pkg::MODE_TSTAMP;
    selPid = 13'h0000;
    {encInValid, encInLast, encOutReady, auStampValid} = 4'h0;
    encInData = 8'h00;
    auStamp = 32'h0000_0000;
    {cyc, err_count, n_tests, nOvf, nUnf} = '0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    encPkt(s1, t1);
    encPkt(s2, t2);
    chk("stamp gap", t2 - t1, s2 - s1);
    i_ndjb_far_end.sendPkt(32'h0000_1000, 3);
    i_ndjb_far_end.sendPkt(32'h0000_100A, 3);
    repeat (3) @(posedge clk);
    chk("fill", 32'h0000_0006, 32'(fillLevel));
    rxPkt(32'h0000_1000);
    rxPkt(32'h0000_100A);
    s1 = 32'(nUnf);
    i_ndjb_far_end.sendPkt(recoveredTime - 32'h0000_01F4, 3);
    repeat (200) @(posedge clk);
    chk("underflow", 32'h1, 32'(nUnf > s1));
    t1 = 32'(nOvf);
    i_ndjb_far_end.sendPkt(recoveredTime + 32'h0000_1388, 1100);
    repeat (3) @(posedge clk);
    chk("overflow", 32'h1, 32'(nOvf > t1));
    chk("cut dropped", 32'h0, 32'(fillLevel));
    auRun();
    wrap_up();
  end
endmodule
